/* File: include/pacfg_consts.vh */
`ifndef PACFG_CONSTS_VH
`define PACFG_CONSTS_VH

// Register indices on the configuration port
`define PACFG_ADDR_W            4
`define PACFG_IDX_PROT          4'h6
`define PACFG_IDX_SUPPLY        4'h7

// Reset values of both configuration words
`define PACFG_RST_PROT          16'h0902
`define PACFG_RST_SUPPLY        16'hAA90

// Field positions, protection threshold word (lsb)
`define PACFG_OC_TH_LSB         12
`define PACFG_SC_TH_LSB         10
`define PACFG_BIAS_LSB          8
`define PACFG_SHORT_CIRCUIT_BLANKING_CODE_LSB        6
`define PACFG_OVERCURRENT_BLANKING_CODE_LSB        3
`define PACFG_TSD_LSB           0

// Field positions, supply lockout and converter word (lsb)
`define PACFG_UV2_LSB           14
`define PACFG_OV2_LSB           12
`define PACFG_UV3_LSB           10
`define PACFG_OV3_LSB           8
`define PACFG_CONV_EN_BIT       7
`define PACFG_MODE_LSB          5
`define PACFG_DLY_LSB           3
`define PACFG_REPORT_BIT        2
`define PACFG_FSTATE_LSB        0

// Fail-safe gate output state codes
`define PACFG_FS_LOW            2'h0
`define PACFG_FS_HIGH           2'h1
`define PACFG_FS_HIZ            2'h2
`define PACFG_FS_NONE           2'h3

// Clock rate and minimum-time conversion, rounded up
`define PACFG_CLK_MHZ           25
`define PACFG_CYC(ns)           ((((ns) * `PACFG_CLK_MHZ) + 999) / 1000)

// Short-circuit blanking times in ns
`define PACFG_SC_BLK0_NS        100
`define PACFG_SC_BLK1_NS        200
`define PACFG_SC_BLK2_NS        400
`define PACFG_SC_BLK3_NS        800

// Overcurrent blanking times in ns
`define PACFG_OC_BLK0_NS        500
`define PACFG_OC_BLK1_NS        1000
`define PACFG_OC_BLK2_NS        1500
`define PACFG_OC_BLK3_NS        2000
`define PACFG_OC_BLK4_NS        2500
`define PACFG_OC_BLK5_NS        3000
`define PACFG_OC_BLK6_NS        5000
`define PACFG_OC_BLK7_NS        10000

// Converter sampling minimum delays in ns
`define PACFG_DLY0_NS           280
`define PACFG_DLY1_NS           560
`define PACFG_DLY2_NS           840
`define PACFG_DLY3_NS           1120

`endif

/* File: rtl/pacfg_regs.v */

`include "pacfg_consts.vh"

module pacfg_regs #(
    parameter ADDR_W = `PACFG_ADDR_W
) (
    input  wire                 clk_sys,
    input  wire                 resetn,
    input  wire                 ce,
    // Configuration port
    input  wire                 cfg_wr_en,
    input  wire                 cfg_rd_en,
    input  wire [ADDR_W-1:0]    cfg_addr,
    input  wire [15:0]          cfg_wdata,
    output reg  [15:0]          cfg_rdata_q,
    output reg                  cfg_rvalid_q,
    // Gate command and comparators
    input  wire                 gate_cmd,
    input  wire                 sc_cmp,
    input  wire                 oc_cmp,
    // Converter fault sources
    input  wire                 vref_ov,
    input  wire                 vref_uv,
    input  wire                 vref_ilim,
    input  wire                 buf_overrun,
    // Threshold and lockout codes
    output reg  [3:0]           overcurrent_threshold_code_q,
    output reg  [1:0]           short_circuit_threshold_code_q,
    output reg  [1:0]           diode_bias_current_code_q,
    output reg  [2:0]           switch_thermal_threshold_code_q,
    output reg  [1:0]           pos_supply_undervolt_code_q,
    output reg  [1:0]           pos_supply_overvolt_code_q,
    output reg  [1:0]           neg_supply_undervolt_code_q,
    output reg  [1:0]           neg_supply_overvolt_code_q,
    // Converter control
    output reg  [1:0]           converter_sampling_mode_q,
    output reg                  sample_req_q,
    // Qualified protection faults
    output reg                  sc_fault_q,
    output reg                  oc_fault_q,
    // Converter fault consequences
    output reg                  converter_fault_q,
    output reg                  fault_alarm_output_n_q,
    output reg                  gate_force_low_q,
    output reg                  gate_force_high_q,
    output reg                  gate_hiz_q
);

    // Cycle counts derived from the interval times
    // Rounded up, so no interval is shorter than its setting
    localparam [31:0] SC_B0 = `PACFG_CYC(`PACFG_SC_BLK0_NS);
    localparam [31:0] SC_B1 = `PACFG_CYC(`PACFG_SC_BLK1_NS);
    localparam [31:0] SC_B2 = `PACFG_CYC(`PACFG_SC_BLK2_NS);
    localparam [31:0] SC_B3 = `PACFG_CYC(`PACFG_SC_BLK3_NS);
    localparam [31:0] OC_B0 = `PACFG_CYC(`PACFG_OC_BLK0_NS);
    localparam [31:0] OC_B1 = `PACFG_CYC(`PACFG_OC_BLK1_NS);
    localparam [31:0] OC_B2 = `PACFG_CYC(`PACFG_OC_BLK2_NS);
    localparam [31:0] OC_B3 = `PACFG_CYC(`PACFG_OC_BLK3_NS);
    localparam [31:0] OC_B4 = `PACFG_CYC(`PACFG_OC_BLK4_NS);
    localparam [31:0] OC_B5 = `PACFG_CYC(`PACFG_OC_BLK5_NS);
    localparam [31:0] OC_B6 = `PACFG_CYC(`PACFG_OC_BLK6_NS);
    localparam [31:0] OC_B7 = `PACFG_CYC(`PACFG_OC_BLK7_NS);
    localparam [31:0] DLY_0 = `PACFG_CYC(`PACFG_DLY0_NS);
    localparam [31:0] DLY_1 = `PACFG_CYC(`PACFG_DLY1_NS);
    localparam [31:0] DLY_2 = `PACFG_CYC(`PACFG_DLY2_NS);
    localparam [31:0] DLY_3 = `PACFG_CYC(`PACFG_DLY3_NS);

    // Sampling sequencer states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    reg  [15:0] prot_q;
    reg  [15:0] supply_q;
    reg         gate_cmd_q;
    reg  [7:0]  sc_cnt_q;
    reg  [7:0]  oc_cnt_q;
    reg  [7:0]  dly_cnt_q;
    reg  [1:0]  samp_st_q;
    reg  [1:0]  samp_st_d;
    reg  [7:0]  dly_cnt_d;
    reg         sample_req_d;
    reg  [15:0] rd_mux;

    wire        gate_rise;
    wire        conv_fault_now;
    wire        conv_en;
    wire        report_en;
    wire [1:0]  fs_state;

    // Short-circuit blanking length in cycles
    function [7:0] sc_blank_cycles;
        input [1:0] code;
        begin
            if (code == 2'h0) begin
                sc_blank_cycles = SC_B0[7:0];
            end else if (code == 2'h1) begin
                sc_blank_cycles = SC_B1[7:0];
            end else if (code == 2'h2) begin
                sc_blank_cycles = SC_B2[7:0];
            end else begin
                sc_blank_cycles = SC_B3[7:0];
            end
        end
    endfunction

    // Overcurrent blanking length in cycles
    function [7:0] oc_blank_cycles;
        input [2:0] code;
        begin
            case (code)
                3'h0: oc_blank_cycles = OC_B0[7:0];
                3'h1: oc_blank_cycles = OC_B1[7:0];
                3'h2: oc_blank_cycles = OC_B2[7:0];
                3'h3: oc_blank_cycles = OC_B3[7:0];
                3'h4: oc_blank_cycles = OC_B4[7:0];
                3'h5: oc_blank_cycles = OC_B5[7:0];
                3'h6: oc_blank_cycles = OC_B6[7:0];
                default: oc_blank_cycles = OC_B7[7:0];
            endcase
        end
    endfunction

    // Minimum sampling delay in cycles
    function [7:0] samp_dly_cycles;
        input [1:0] code;
        begin
            case (code)
                2'h0: samp_dly_cycles = DLY_0[7:0];
                2'h1: samp_dly_cycles = DLY_1[7:0];
                2'h2: samp_dly_cycles = DLY_2[7:0];
                default: samp_dly_cycles = DLY_3[7:0];
            endcase
        end
    endfunction

    // Field views of the stored words
    // Mode code 3 is stored as written and not acted on
    assign conv_en   = supply_q[`PACFG_CONV_EN_BIT];
    assign report_en = supply_q[`PACFG_REPORT_BIT];
    assign fs_state  = supply_q[`PACFG_FSTATE_LSB +: 2];
    assign gate_rise = gate_cmd & ~gate_cmd_q;

    // Any of the four converter fault sources
    assign conv_fault_now = vref_ov | vref_uv | vref_ilim | buf_overrun;

    // Register writes, whole 16-bit words
    // Writes to other indices are dropped with no flag
    always @(posedge clk_sys) begin
        if (!resetn) begin
            prot_q   <= `PACFG_RST_PROT;
            supply_q <= `PACFG_RST_SUPPLY;
        end else if (ce && cfg_wr_en) begin
            if (cfg_addr == `PACFG_IDX_PROT) begin
                prot_q <= cfg_wdata;
            end else if (cfg_addr == `PACFG_IDX_SUPPLY) begin
                supply_q <= cfg_wdata;
            end
        end
    end

    // Read decode, unmapped reads as zero
    always @* begin
        if (cfg_addr == `PACFG_IDX_PROT) begin
            rd_mux = prot_q;
        end else if (cfg_addr == `PACFG_IDX_SUPPLY) begin
            rd_mux = supply_q;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Registered read answer, one cycle after the request
    // A read in the cycle of a write returns the old word
    always @(posedge clk_sys) begin
        if (!resetn) begin
            cfg_rdata_q  <= 16'h0000;
            cfg_rvalid_q <= 1'b0;
        end else if (ce) begin
            cfg_rvalid_q <= cfg_rd_en;
            if (cfg_rd_en) begin
                cfg_rdata_q <= rd_mux;
            end
        end
    end

    // Threshold and lockout codes driven to the analog side
    // Codes trail the stored words by one cycle
    always @(posedge clk_sys) begin
        if (!resetn) begin
            overcurrent_threshold_code_q    <= 4'h0;
            short_circuit_threshold_code_q  <= 2'h2;
            diode_bias_current_code_q       <= 2'h1;
            switch_thermal_threshold_code_q <= 3'h2;
            pos_supply_undervolt_code_q     <= 2'h2;
            pos_supply_overvolt_code_q      <= 2'h2;
            neg_supply_undervolt_code_q     <= 2'h2;
            neg_supply_overvolt_code_q      <= 2'h2;
            converter_sampling_mode_q       <= 2'h0;
        end else if (ce) begin
            overcurrent_threshold_code_q    <= prot_q[`PACFG_OC_TH_LSB +: 4];
            short_circuit_threshold_code_q  <= prot_q[`PACFG_SC_TH_LSB +: 2];
            diode_bias_current_code_q       <= prot_q[`PACFG_BIAS_LSB +: 2];
            switch_thermal_threshold_code_q <= prot_q[`PACFG_TSD_LSB +: 3];
            pos_supply_undervolt_code_q     <= supply_q[`PACFG_UV2_LSB +: 2];
            pos_supply_overvolt_code_q      <= supply_q[`PACFG_OV2_LSB +: 2];
            neg_supply_undervolt_code_q     <= supply_q[`PACFG_UV3_LSB +: 2];
            neg_supply_overvolt_code_q      <= supply_q[`PACFG_OV3_LSB +: 2];
            converter_sampling_mode_q       <= supply_q[`PACFG_MODE_LSB +: 2];
        end
    end

    // Gate command edge history
    always @(posedge clk_sys) begin
        if (!resetn) begin
            gate_cmd_q <= 1'b0;
        end else if (ce) begin
            gate_cmd_q <= gate_cmd;
        end
    end

    // Blanking counters loaded at gate turn-on, counting down to zero
    // Gate off drops any interval left, a new turn-on reloads it
    always @(posedge clk_sys) begin
        if (!resetn) begin
            sc_cnt_q <= 8'h00;
            oc_cnt_q <= 8'h00;
        end else if (ce) begin
            if (gate_rise) begin
                sc_cnt_q <= sc_blank_cycles(prot_q[`PACFG_SHORT_CIRCUIT_BLANKING_CODE_LSB +: 2]);
                oc_cnt_q <= oc_blank_cycles(prot_q[`PACFG_OVERCURRENT_BLANKING_CODE_LSB +: 3]);
            end else if (!gate_cmd) begin
                sc_cnt_q <= 8'h00;
                oc_cnt_q <= 8'h00;
            end else begin
                if (sc_cnt_q != 8'h00) begin
                    sc_cnt_q <= sc_cnt_q - 8'h01;
                end
                if (oc_cnt_q != 8'h00) begin
                    oc_cnt_q <= oc_cnt_q - 8'h01;
                end
            end
        end
    end

    // Faults count only once blanking has run out while the gate is on
    // The turn-on cycle itself is blanked whatever the count
    always @(posedge clk_sys) begin
        if (!resetn) begin
            sc_fault_q <= 1'b0;
            oc_fault_q <= 1'b0;
        end else if (ce) begin
            sc_fault_q <= gate_cmd & ~gate_rise & (sc_cnt_q == 8'h00) & sc_cmp;
            oc_fault_q <= gate_cmd & ~gate_rise & (oc_cnt_q == 8'h00) & oc_cmp;
        end
    end

    // Sampling sequencer next state
    // Gate off while waiting drops the pending sample, the next turn-on counts afresh
    always @* begin
        samp_st_d    = samp_st_q;
        dly_cnt_d    = dly_cnt_q;
        sample_req_d = 1'b0;
        case (samp_st_q)
            ST_IDLE: begin
                if (gate_rise && conv_en) begin
                    dly_cnt_d = samp_dly_cycles(supply_q[`PACFG_DLY_LSB +: 2]);
                    samp_st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!conv_en) begin
                    samp_st_d = ST_IDLE;
                end else if (!gate_cmd) begin
                    samp_st_d = ST_IDLE;
                end else if (dly_cnt_q <= 8'h01) begin
                    sample_req_d = 1'b1;
                    samp_st_d    = ST_DONE;
                end else begin
                    dly_cnt_d = dly_cnt_q - 8'h01;
                end
            end
            ST_DONE: begin
                if (!gate_cmd) begin
                    samp_st_d = ST_IDLE;
                end
            end
            default: begin
                samp_st_d = ST_IDLE;
            end
        endcase
    end

    // Sampling sequencer registers
    always @(posedge clk_sys) begin
        if (!resetn) begin
            samp_st_q    <= ST_IDLE;
            dly_cnt_q    <= 8'h00;
            sample_req_q <= 1'b0;
        end else if (ce) begin
            samp_st_q    <= samp_st_d;
            dly_cnt_q    <= dly_cnt_d;
            sample_req_q <= sample_req_d & conv_en;
        end
    end

    // Converter fault, alarm routing and fail-safe gate state
    // Level only, the outputs follow the sources one cycle late
    always @(posedge clk_sys) begin
        if (!resetn) begin
            converter_fault_q      <= 1'b0;
            fault_alarm_output_n_q <= 1'b1;
            gate_force_low_q       <= 1'b0;
            gate_force_high_q      <= 1'b0;
            gate_hiz_q             <= 1'b0;
        end else if (ce) begin
            converter_fault_q      <= conv_fault_now;
            fault_alarm_output_n_q <= ~(conv_fault_now & report_en);
            gate_force_low_q  <= conv_fault_now & (fs_state == `PACFG_FS_LOW);
            gate_force_high_q <= conv_fault_now & (fs_state == `PACFG_FS_HIGH);
            gate_hiz_q        <= conv_fault_now & (fs_state == `PACFG_FS_HIZ);
        end
    end

endmodule // pacfg_regs

/* File: verification/pacfg_regs_sva.sv */
module pacfg_regs_chk (
    input logic        clk_sys,
    input logic        resetn,
    input logic        ce,
    input logic        cfg_rd_en,
    input logic [15:0] cfg_rdata_q,
    input logic        cfg_rvalid_q,
    input logic        gate_cmd,
    input logic        sc_cmp,
    input logic        oc_cmp,
    input logic        vref_ov,
    input logic        vref_uv,
    input logic        vref_ilim,
    input logic        buf_overrun,
    input logic        sc_fault_q,
    input logic        oc_fault_q,
    input logic        sample_req_q,
    input logic        converter_fault_q,
    input logic        fault_alarm_output_n_q,
    input logic        gate_force_low_q,
    input logic        gate_force_high_q,
    input logic        gate_hiz_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Turn-on edge and the shortest quiet windows after it
    sequence gate_rise_s;
        $rose(gate_cmd);
    endsequence
    sequence sc_quiet_s;
        !sc_fault_q [*4];
    endsequence
    sequence oc_quiet_s;
        !oc_fault_q [*8];
    endsequence
    sequence sample_quiet_s;
        !sample_req_q [*8];
    endsequence
    // Register port answers
    rd_answer_a: assert property (ce |=> cfg_rvalid_q == $past(cfg_rd_en))
        else $error("read valid not one cycle after read strobe");
    rd_hold_a: assert property (!$past(cfg_rd_en) && $past(resetn)
        |-> $stable(cfg_rdata_q))
        else $error("read data changed without a read");
    // Blanking after turn-on
    sc_blank_a: assert property (gate_rise_s |-> sc_quiet_s)
        else $error("short-circuit fault inside blanking");
    oc_blank_a: assert property (gate_rise_s |-> oc_quiet_s)
        else $error("overcurrent fault inside blanking");
    blank_cause_a: assert property (sc_fault_q || oc_fault_q
        |-> $past(gate_cmd) && $past(sc_cmp || oc_cmp))
        else $error("fault without gate on and comparator trip");
    gate_off_a: assert property (!gate_cmd |=> !sc_fault_q && !oc_fault_q)
        else $error("fault held after gate off");
    // Converter sampling
    sample_wait_a: assert property (gate_rise_s |-> sample_quiet_s)
        else $error("sample request before minimum delay");
    sample_pulse_a: assert property (sample_req_q |=> !sample_req_q)
        else $error("sample request longer than one cycle");
    // Converter fault consequences
    conv_fault_a: assert property (converter_fault_q
        == $past(vref_ov | vref_uv | vref_ilim | buf_overrun))
        else $error("converter fault does not follow its sources");
    alarm_cause_a: assert property (!fault_alarm_output_n_q |-> converter_fault_q)
        else $error("alarm without converter fault");
    force_one_a: assert property ((gate_force_low_q | gate_force_high_q | gate_hiz_q)
        |-> converter_fault_q && $onehot0({gate_force_low_q, gate_force_high_q, gate_hiz_q}))
        else $error("bad fail-safe gate request");
endmodule // pacfg_regs_chk

bind pacfg_regs pacfg_regs_chk i_chk (
    .clk_sys, .resetn, .ce, .cfg_rd_en, .cfg_rdata_q, .cfg_rvalid_q, .gate_cmd, .sc_cmp, .oc_cmp,
    .vref_ov, .vref_uv, .vref_ilim, .buf_overrun, .sc_fault_q, .oc_fault_q, .sample_req_q,
    .converter_fault_q, .fault_alarm_output_n_q, .gate_force_low_q, .gate_force_high_q,
    .gate_hiz_q
);

/* File: verification/pacfg_host.sv */
module pacfg_host (
    input  logic        clk_sys,
    output logic        cfg_wr_en,
    output logic        cfg_rd_en,
    output logic [3:0]  cfg_addr,
    output logic [15:0] cfg_wdata,
    input  logic [15:0] cfg_rdata_q,
    input  logic        cfg_rvalid_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port from time zero
    initial begin
        cfg_wr_en = 1'b0;
        cfg_rd_en = 1'b0;
        cfg_addr  = 4'h0;
        cfg_wdata = 16'h0000;
    end
    // One-cycle write strobe, then scrambled idle lines
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        cfg_wr_en = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(negedge clk_sys);
        cfg_wr_en = 1'b0;
        cfg_addr  = ~a;
        cfg_wdata = ~d;
    endtask
    // One-cycle read strobe, answer taken one edge later
    task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        cfg_rd_en = 1'b1;
        cfg_addr  = a;
        @(negedge clk_sys);
        cfg_rd_en = 1'b0;
        cfg_addr  = ~a;
        ok = cfg_rvalid_q;
        d  = cfg_rdata_q;
    endtask
endmodule // pacfg_host

/* File: verification/test_pacfg_regs.sv */
module test_pacfg_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys  = 1'b0;
    logic        resetn   = 1'b0;
    logic        ce       = 1'b1;
    logic        gate_cmd = 1'b0;
    logic        sc_cmp   = 1'b0;
    logic        oc_cmp   = 1'b0;
    logic [3:0]  src      = 4'h0;
    wire         vref_ov = src[0], vref_uv = src[1], vref_ilim = src[2], buf_overrun = src[3];
    wire         cfg_wr_en, cfg_rd_en, cfg_rvalid_q;
    wire [3:0]   cfg_addr, overcurrent_threshold_code_q;
    wire [15:0]  cfg_wdata, cfg_rdata_q;
    wire [2:0]   switch_thermal_threshold_code_q;
    wire [1:0]   short_circuit_threshold_code_q, diode_bias_current_code_q;
    wire [1:0]   pos_supply_undervolt_code_q, pos_supply_overvolt_code_q;
    wire [1:0]   neg_supply_undervolt_code_q, neg_supply_overvolt_code_q, converter_sampling_mode_q;
    wire         sample_req_q, sc_fault_q, oc_fault_q, converter_fault_q, fault_alarm_output_n_q;
    wire         gate_force_low_q, gate_force_high_q, gate_hiz_q;
    int          err_total = 0;
    int          num_checks = 0;
    int          sc_ns[4] = '{100, 200, 400, 800};
    int          oc_ns[8] = '{500, 1000, 1500, 2000, 2500, 3000, 5000, 10000};
    int          dly_ns[4] = '{280, 560, 840, 1120};

    always #20 clk_sys = ~clk_sys;

    pacfg_regs i_dut (
        .clk_sys, .resetn, .ce, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata, .cfg_rdata_q,
        .cfg_rvalid_q, .gate_cmd, .sc_cmp, .oc_cmp, .vref_ov, .vref_uv, .vref_ilim, .buf_overrun,
        .overcurrent_threshold_code_q, .short_circuit_threshold_code_q, .diode_bias_current_code_q,
        .switch_thermal_threshold_code_q, .pos_supply_undervolt_code_q, .pos_supply_overvolt_code_q,
        .neg_supply_undervolt_code_q, .neg_supply_overvolt_code_q, .converter_sampling_mode_q,
        .sample_req_q, .sc_fault_q, .oc_fault_q, .converter_fault_q, .fault_alarm_output_n_q,
        .gate_force_low_q, .gate_force_high_q, .gate_hiz_q
    );
    pacfg_host i_host (
        .clk_sys, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata, .cfg_rdata_q, .cfg_rvalid_q
    );

    // Minimum time in whole 40 ns cycles, rounded up
    function automatic int cyc(input int ns);
        return (ns * 25 + 999) / 1000;
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] q;
        logic        ok;
        i_host.rd(a, q, ok);
        chk("rvalid", 16'h0001, {15'h0, ok});
        chk("rdata", e, q);
    endtask
    // Code outputs against the stored words
    task automatic chk_codes(input logic [15:0] p, input logic [15:0] s);
        chk("oc_th", p[15:12], overcurrent_threshold_code_q);
        chk("sc_th", p[11:10], short_circuit_threshold_code_q);
        chk("bias", p[9:8], diode_bias_current_code_q);
        chk("tsd", p[2:0], switch_thermal_threshold_code_q);
        chk("uv2", s[15:14], pos_supply_undervolt_code_q);
        chk("ov2", s[13:12], pos_supply_overvolt_code_q);
        chk("uv3", s[11:10], neg_supply_undervolt_code_q);
        chk("ov3", s[9:8], neg_supply_overvolt_code_q);
        chk("mode", s[6:5], converter_sampling_mode_q);
    endtask

    // Main sequence
    initial begin
        logic [15:0] p;
        logic [15:0] s;
        int          n_sc;
        int          n_oc;
        int          n_sm;
        void'($urandom(24));
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        chk_codes(16'h0902, 16'hAA90);
        rd_chk(4'h6, 16'h0902);
        rd_chk(4'h7, 16'hAA90);
        // Random words, writes and reads at unmapped indices
        repeat (16) begin
            p = 16'($urandom);
            s = 16'($urandom);
            i_host.wr(4'h6, p);
            i_host.wr(4'h7, s);
            i_host.wr(4'($urandom_range(0, 5)), ~p);
            rd_chk(4'h6, p);
            rd_chk(4'h7, s);
            rd_chk(4'($urandom_range(8, 15)), 16'h0000);
            chk_codes(p, s);
        end
        // Clock enable low drops a write, then a mid-run reset restores both words
        ce = 1'b0;
        i_host.wr(4'h6, ~p);
        ce = 1'b1;
        rd_chk(4'h6, p);
        resetn = 1'b0;
        @(negedge clk_sys);
        resetn = 1'b1;
        rd_chk(4'h6, 16'h0902);
        rd_chk(4'h7, 16'hAA90);
        chk_codes(16'h0902, 16'hAA90);
        // Blanking and sampling delay for every code, last pass with sampling off
        for (int i = 0; i < 9; i++) begin
            p = {4'($urandom), 2'($urandom), 2'($urandom), 2'(i), 3'(i), 3'($urandom)};
            s = {8'($urandom), (i < 8), 2'($urandom), 2'(i), 3'($urandom)};
            i_host.wr(4'h6, p);
            i_host.wr(4'h7, s);
            n_sc = 0;
            n_oc = 0;
            n_sm = 0;
            gate_cmd = 1'b1;
            sc_cmp = 1'b1;
            oc_cmp = 1'b1;
            for (int n = 1; n <= 300; n++) begin
                @(negedge clk_sys);
                if (sc_fault_q === 1'b1 && n_sc == 0) n_sc = n;
                if (oc_fault_q === 1'b1 && n_oc == 0) n_oc = n;
                if (sample_req_q === 1'b1 && n_sm == 0) n_sm = n;
            end
            chk("sc_delay", 16'(cyc(sc_ns[i % 4]) + 2), 16'(n_sc));
            chk("oc_delay", 16'(cyc(oc_ns[i % 8]) + 2), 16'(n_oc));
            chk("sample_delay", (i < 8) ? 16'(cyc(dly_ns[i % 4]) + 1) : 16'h0, 16'(n_sm));
            gate_cmd = 1'b0;
            @(negedge clk_sys);
            chk("fault_off", 16'h0000, {14'h0, sc_fault_q, oc_fault_q});
            sc_cmp = 1'b0;
            oc_cmp = 1'b0;
        end
        // Each converter fault source against report bit and fail-safe code
        for (int i = 0; i < 16; i++) begin
            s = {8'hAA, 1'b0, 2'($urandom), 2'($urandom), 1'(i >> 2), 2'(i)};
            i_host.wr(4'h7, s);
            src = 4'b0001 << (i % 4);
            @(negedge clk_sys);
            chk("conv_fault", 16'h0001, {15'h0, converter_fault_q});
            chk("alarm_n", {15'h0, ~s[2]}, {15'h0, fault_alarm_output_n_q});
            chk("force", {13'h0, s[1:0] == 2'h0, s[1:0] == 2'h1, s[1:0] == 2'h2},
                {13'h0, gate_force_low_q, gate_force_high_q, gate_hiz_q});
            src = 4'h0;
            @(negedge clk_sys);
            chk("alarm_off", 16'h0001, {15'h0, fault_alarm_output_n_q});
        end
        final_report();
    end
endmodule // test_pacfg_regs
